// file: shared/vir_map.vh
// Constants for the vectored interrupt register set.
// Assumes byte addresses within the 4 KB block on the Avalon bus.
`ifndef VIR_MAP_VH
`define VIR_MAP_VH

`define VIR_NUM_IRQ 42
`define VIR_IRQ_W 6
`define VIR_PRI_W 4
`define VIR_ADDR_W 12
`define VIR_NUM_IPR 11

// Register byte offsets, bits [11:0] of the printed addresses
`define VIR_OFS_ENA_SET 12'h100
`define VIR_OFS_ENA_CLR 12'h180
`define VIR_OFS_PND_SET 12'h200
`define VIR_OFS_PND_CLR 12'h280
`define VIR_OFS_ACTIVE 12'h300
`define VIR_OFS_PRIO 12'h400
`define VIR_OFS_TRIGGER 12'hF00

// Group layout: two words per bit group, eleven priority words
`define VIR_GRP_MASK 12'hF80
`define VIR_GRP_LAST 5'h01
`define VIR_PRIO_LAST 10'h00A
`define VIR_PRIO_MSB 7
`define VIR_PRIO_LSB 4
`define VIR_TRIG_MSB 8

`define VIR_RESET_WORD 32'h00000000
`define VIR_PRI_LOWEST 4'hF

`endif

// file: rtl/vir_top.v
// Vectored interrupt register set: enable, pending, active and priority
// state for 42 interrupts, plus selection of the next one to take.
// Assumes request lines and core handshakes are synchronous to clk_sys.
//
// Notes on behaviour
// RULE_01 - Set-enable write ones enable; reads show enables
// RULE_02 - Clear-enable write ones disable; reads show enables
// RULE_03 - Pending and enabled interrupts compete by priority
// RULE_04 - Disabled interrupts still pend, never activate
// RULE_05 - Set-pending write ones pend; reads show pending
// RULE_06 - Set-pending ignores already pending; works if disabled
// RULE_07 - Clear-pending write ones unpend; reads show pending
// RULE_08 - Clear-pending leaves active state untouched
// RULE_09 - Active bits read one while active
// RULE_10 - Four byte-wide priority fields per word
// RULE_11 - Only priority bits 7:4 stored; rest zero
// RULE_12 - Priority 0 to 15, lower is more urgent
// RULE_13 - Interrupt m at word m/4, lane m%4
// RULE_14 - Trigger register write pends numbered interrupt
// RULE_15 - All registers reset to zero
// RULE_16 - Word 0 holds interrupts 0-31, word 1 32-41
// RULE_17 - Level while inactive, or rising edge, sets pending
// RULE_18 - Handler entry moves pending to active
// RULE_19 - Clear-pending ignored while level line high
// RULE_20 - Equal priority ties go to lowest number
`timescale 1ns/100ps
`include "vir_map.vh"

module vir_top (
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // Avalon-MM slave
    input wire [`VIR_ADDR_W-1:0] avs_address,
    input wire [3:0] avs_byteenable,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Peripheral request lines
    input wire [`VIR_NUM_IRQ-1:0] irq_line,
    // Core side
    input wire core_take,
    input wire core_return,
    input wire [`VIR_IRQ_W-1:0] core_return_num,
    output reg cand_valid_q,
    output reg [`VIR_IRQ_W-1:0] cand_num_q,
    output reg [`VIR_PRI_W-1:0] cand_pri_q
);

    // Byte enables widened to a bit mask
    function [31:0] lane_mask;
        input [3:0] be;
        begin
            lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        end
    endfunction

    // Place a 32-bit word into the 42-bit vector at the selected word
    function [`VIR_NUM_IRQ-1:0] to_vec;
        input word_sel;
        input [31:0] word;
        begin
            if (word_sel) begin
                to_vec = {word[`VIR_NUM_IRQ-33:0], 32'h00000000};
            end else begin
                to_vec = {10'h000, word};
            end
        end
    endfunction

    // Pick a 32-bit word out of the 42-bit vector
    function [31:0] from_vec;
        input word_sel;
        input [`VIR_NUM_IRQ-1:0] vec;
        begin
            if (word_sel) begin
                from_vec = {22'h000000, vec[`VIR_NUM_IRQ-1:32]};
            end else begin
                from_vec = vec[31:0];
            end
        end
    endfunction

    reg [`VIR_NUM_IRQ-1:0] enable_q;
    reg [`VIR_NUM_IRQ-1:0] pend_q;
    reg [`VIR_NUM_IRQ-1:0] active_q;
    reg [`VIR_NUM_IRQ-1:0] line_q;
    reg [`VIR_PRI_W-1:0] pri_q [0:`VIR_NUM_IRQ-1];
    reg [`VIR_NUM_IRQ-1:0] enable_d;
    reg [`VIR_NUM_IRQ-1:0] pend_d;
    reg [`VIR_NUM_IRQ-1:0] active_d;
    reg [31:0] rdata_d;
    reg best_valid_d;
    reg [`VIR_IRQ_W-1:0] best_num_d;
    reg [`VIR_PRI_W-1:0] best_pri_d;
    integer i;

    // Address decode; bit 2 picks the word within a bit group
    wire [`VIR_ADDR_W-1:0] grp_base = avs_address & `VIR_GRP_MASK;
    wire [4:0] grp_word = avs_address[6:2];
    wire grp_ok = (grp_word <= `VIR_GRP_LAST);
    wire wsel = avs_address[2];
    wire [9:0] prio_word = avs_address[11:2];
    wire prio_hit = (avs_address >= `VIR_OFS_PRIO) &&
        (prio_word <= (`VIR_PRIO_LAST + `VIR_OFS_PRIO / 4));
    wire [3:0] prio_idx = prio_word[3:0];
    wire [31:0] wmask = lane_mask(avs_byteenable);
    wire [31:0] wbits = avs_writedata & wmask;

    // A write is performed on the edge where waitrequest is seen low
    wire acc_go = ~avs_waitrequest;
    wire wr_go = acc_go & avs_write;
    wire wr_en_set = wr_go && grp_ok && grp_base == `VIR_OFS_ENA_SET;
    wire wr_en_clr = wr_go && grp_ok && grp_base == `VIR_OFS_ENA_CLR;
    wire wr_pn_set = wr_go && grp_ok && grp_base == `VIR_OFS_PND_SET;
    wire wr_pn_clr = wr_go && grp_ok && grp_base == `VIR_OFS_PND_CLR;
    wire wr_prio = wr_go && prio_hit;
    wire wr_trig = wr_go && avs_address == `VIR_OFS_TRIGGER;

    wire [`VIR_NUM_IRQ-1:0] en_set_v = wr_en_set ? to_vec(wsel, wbits) : 0;
    wire [`VIR_NUM_IRQ-1:0] en_clr_v = wr_en_clr ? to_vec(wsel, wbits) : 0;
    wire [`VIR_NUM_IRQ-1:0] pn_set_v = wr_pn_set ? to_vec(wsel, wbits) : 0;
    wire [`VIR_NUM_IRQ-1:0] pn_clr_v = wr_pn_clr ? to_vec(wsel, wbits) : 0;

    // Trigger number decoded to one bit; numbers past 41 hit nothing
    wire [`VIR_TRIG_MSB:0] trig_num = avs_writedata[`VIR_TRIG_MSB:0];
    wire [`VIR_NUM_IRQ-1:0] trig_v = (wr_trig && avs_byteenable[1:0] == 2'h3
        && trig_num < `VIR_NUM_IRQ) ?
        ({{(`VIR_NUM_IRQ-1){1'b0}}, 1'b1} << trig_num[`VIR_IRQ_W-1:0]) : 0;

    // Core handshakes as bit vectors; take uses the offered candidate
    wire [`VIR_NUM_IRQ-1:0] take_v = (core_take && cand_valid_q) ?
        ({{(`VIR_NUM_IRQ-1){1'b0}}, 1'b1} << cand_num_q) : 0;
    wire [`VIR_NUM_IRQ-1:0] ret_v = core_return ?
        ({{(`VIR_NUM_IRQ-1){1'b0}}, 1'b1} << core_return_num) : 0;
    wire [`VIR_NUM_IRQ-1:0] rise_v = irq_line & ~line_q;

    // Next state of the enable, pending and active vectors
    always @* begin
        enable_d = (enable_q | en_set_v) & ~en_clr_v; // RULE_01 RULE_02
        // Level rule skips the take cycle so the take really clears pending
        pend_d = (pend_q & ~(pn_clr_v & ~irq_line) & ~take_v) // RULE_19
            | (irq_line & ~active_q & ~take_v) // RULE_17
            | rise_v // RULE_17
            | pn_set_v // RULE_05 RULE_06
            | trig_v; // RULE_14
        active_d = (active_q | take_v) & ~ret_v; // RULE_18 RULE_08
    end

    // Read mux, built one cycle before the answer
    always @* begin
        rdata_d = `VIR_RESET_WORD;
        if (prio_hit) begin
            for (i = 0; i < 4; i = i + 1) begin
                if (prio_idx * 4 + i < `VIR_NUM_IRQ) begin
                    rdata_d[i*8 + `VIR_PRIO_LSB +: `VIR_PRI_W] =
                        pri_q[prio_idx * 4 + i]; // RULE_11 RULE_13
                end
            end
        end else if (grp_ok) begin
            case (grp_base)
                `VIR_OFS_ENA_SET: rdata_d = from_vec(wsel, enable_q);
                `VIR_OFS_ENA_CLR: rdata_d = from_vec(wsel, enable_q);
                `VIR_OFS_PND_SET: rdata_d = from_vec(wsel, pend_q);
                `VIR_OFS_PND_CLR: rdata_d = from_vec(wsel, pend_q);
                `VIR_OFS_ACTIVE: rdata_d = from_vec(wsel, active_q); // RULE_09
                default: rdata_d = `VIR_RESET_WORD;
            endcase
        end
    end

    // Arbitration: strict less-than keeps the lowest number on a tie
    always @* begin
        best_valid_d = 1'b0;
        best_num_d = {`VIR_IRQ_W{1'b0}};
        best_pri_d = `VIR_PRI_LOWEST;
        for (i = 0; i < `VIR_NUM_IRQ; i = i + 1) begin
            if (pend_q[i] && enable_q[i] && !active_q[i]) begin // RULE_03 RULE_04
                if (!best_valid_d || pri_q[i] < best_pri_d) begin // RULE_12 RULE_20
                    best_valid_d = 1'b1;
                    best_num_d = i[`VIR_IRQ_W-1:0];
                    best_pri_d = pri_q[i];
                end
            end
        end
    end

    // Bus handshake: one wait cycle, then a one-cycle answer
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= `VIR_RESET_WORD;
        end else begin
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= avs_read ? rdata_d : `VIR_RESET_WORD;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // Interrupt state and candidate output
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            enable_q <= 0; // RULE_15
            pend_q <= 0;
            active_q <= 0;
            line_q <= 0;
            cand_valid_q <= 1'b0;
            cand_num_q <= {`VIR_IRQ_W{1'b0}};
            cand_pri_q <= {`VIR_PRI_W{1'b0}};
        end else begin
            enable_q <= enable_d;
            pend_q <= pend_d;
            active_q <= active_d;
            line_q <= irq_line;
            // Dropped on a take so the same number is not offered twice
            cand_valid_q <= best_valid_d && !(core_take && cand_valid_q);
            cand_num_q <= best_num_d;
            cand_pri_q <= best_pri_d;
        end
    end

    // Priority fields, written per byte lane, upper nibble only
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (i = 0; i < `VIR_NUM_IRQ; i = i + 1) begin
                pri_q[i] <= {`VIR_PRI_W{1'b0}}; // RULE_15
            end
        end else if (wr_prio) begin
            for (i = 0; i < 4; i = i + 1) begin
                if (avs_byteenable[i] && prio_idx * 4 + i < `VIR_NUM_IRQ) begin
                    pri_q[prio_idx * 4 + i] <= avs_writedata[i*8 +
                        `VIR_PRIO_LSB +: `VIR_PRI_W]; // RULE_10 RULE_11 RULE_13
                end
            end
        end
    end

    // Word 0 carries interrupts 0-31, word 1 interrupts 32-41 (RULE_16 in
    // to_vec and from_vec above); bits past 41 read zero
    // RULE_16

endmodule

// file: bench/vir_core_model.sv
// Core stand-in: takes the offered interrupt, returns it on command
// Assumes the single-clock core handshake of vir_top
`timescale 1ns/100ps
module vir_core_model (
    // Clock, reset and bench commands
    input logic clk_sys, reset, auto_take, do_return,
    // Candidate from the block
    input logic cand_valid_q,
    input logic [5:0] cand_num_q,
    // Handshake to the block
    output logic core_take, core_return,
    output logic [5:0] core_return_num, last_num
);
    // Skips a cycle after a take, since valid drops one cycle late
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            core_take <= 0;
            core_return <= 0;
            last_num <= 0;
        end else begin
            core_take <= auto_take && cand_valid_q && !core_take;
            core_return <= do_return;
            if (core_take && cand_valid_q) last_num <= cand_num_q;
        end
    end
    assign core_return_num = last_num;
endmodule

// file: bench/vir_top_monitor.sv
// Port checker for the interrupt register set
// Assumes it is bound to vir_top and connected by port name
`timescale 1ns/100ps
`include "vir_map.vh"
module vir_top_monitor (
    // Clock and reset
    input logic clk_sys,
    input logic reset,
    // Bus
    input logic [`VIR_ADDR_W-1:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic avs_waitrequest,
    input logic [31:0] avs_readdata,
    // Core
    input logic core_take,
    input logic cand_valid_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // A read taken at this edge; its data stand one edge later
    sequence rd_go;
        avs_read && avs_waitrequest;
    endsequence
    req_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("request not answered");
    wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low too long");
    data_hold_a: assert property (avs_waitrequest && $past(avs_waitrequest)
        |-> $stable(avs_readdata)) else $error("read data moved");
    trig_read_a: assert property (rd_go ##0 avs_address == 12'hF00
        |=> avs_readdata == 32'h0) else $error("trigger readable");
    pri_low_a: assert property (rd_go ##0 avs_address[11:8] == 4'h4
        |=> (avs_readdata & 32'h0F0F0F0F) == 32'h0) else $error("low bits");
    word_top_a: assert property (rd_go ##0 avs_address[6:0] == 7'h04
        && avs_address[11:8] inside {4'h1, 4'h2, 4'h3}
        |=> avs_readdata[31:10] == 22'h0) else $error("bits above 41");
    unmapped_zero_a: assert property (rd_go ##0 avs_address == 12'h008
        |=> avs_readdata == 32'h0) else $error("unmapped read");
    take_drop_a: assert property (core_take && cand_valid_q
        |=> !cand_valid_q) else $error("candidate kept after take");
endmodule

// file: bench/vir_top_test.sv
// Self-checking bench for the interrupt register set
// Assumes the core model and the port checker are compiled first
`timescale 1ns/100ps
`include "vir_map.vh"
module vir_top_test;
    logic clk_sys = 0, reset = 1, avs_read = 0, avs_write = 0;
    logic [11:0] avs_address = 0;
    logic [3:0] avs_byteenable = 0, cand_pri_q;
    logic [31:0] avs_writedata = 0, avs_readdata, rdat;
    logic avs_waitrequest, core_take, core_return, cand_valid_q;
    logic auto_take = 0, do_return = 0;
    logic [41:0] irq_line = 0;
    logic [5:0] core_return_num, cand_num_q, last_num;
    int miscompares = 0, check_count = 0;
    vir_top dut (.*);
    vir_core_model core (.*);
    initial forever #2.5 clk_sys = ~clk_sys;
    task results;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One bus cycle, held until waitrequest is sampled low
    task acc(input logic w, input logic [11:0] a, input logic [3:0] be,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_byteenable <= be;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        rdat = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
        if (n >= 40) begin
            miscompares++;
            results();
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        acc(1, a, 4'hF, d);
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        acc(0, a, 4'hF, 32'h0);
        chk(rdat, e);
    endtask
    // Candidate settles within the note's two-cycle lag
    task cnd(input logic [10:0] e);
        repeat (3) @(posedge clk_sys);
        // Priority only means something while a candidate is offered
        chk({21'h0, cand_valid_q, cand_num_q, e[10] ? cand_pri_q : 4'h0},
            {21'h0, e});
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        reset <= 0;
        for (int i = 0; i < 11; i++) rd(12'h400 + 12'(4 * i), 0);
        for (int i = 0; i < 5; i++) rd(12'h100 + 12'(128 * i), 0);
        $display("test reset done");
        wr(12'h100, 32'h5);
        wr(12'h104, 32'hFFFFFFFF);
        rd(12'h180, 32'h5);
        rd(12'h184, 32'h3FF);
        wr(12'h180, 32'h1);
        wr(12'h100, 32'h0);
        rd(12'h100, 32'h4);
        wr(12'h200, 32'h1);
        wr(12'h200, 32'h1);
        rd(12'h280, 32'h1);
        cnd(11'h0);
        wr(12'h280, 32'h1);
        rd(12'h200, 32'h0);
        acc(1, 12'h404, 4'h2, 32'hFFFFFFFF);
        rd(12'h404, 32'h0000F000);
        acc(1, 12'h400, 4'hC, 32'h3757A5A5);
        rd(12'h400, 32'h30500000);
        acc(1, 12'hF00, 4'h3, 32'h3);
        acc(1, 12'hF00, 4'h3, 32'hEF);
        rd(12'h200, 32'h8);
        rd(12'h204, 32'h0);
        rd(12'hF00, 32'h0);
        rd(12'h008, 32'h0);
        $display("test registers done");
        wr(12'h100, 32'h8);
        wr(12'h200, 32'h4);
        cnd({1'b1, 6'd3, 4'd3});
        acc(1, 12'h400, 4'h8, 32'h50000000);
        cnd({1'b1, 6'd2, 4'd5});
        wr(12'h180, 32'h8);
        auto_take <= 1;
        for (int n = 0; n < 20 && core_take !== 1'b1; n++) @(posedge clk_sys);
        auto_take <= 0;
        chk(core_take, 1);
        rd(12'h300, 32'h4);
        rd(12'h200, 32'h8);
        wr(12'h200, 32'h4);
        wr(12'h280, 32'h4);
        rd(12'h300, 32'h4);
        rd(12'h304, 32'h0);
        irq_line[2] <= 1;
        wr(12'h280, 32'h4);
        rd(12'h200, 32'hC);
        do_return <= 1;
        @(posedge clk_sys) do_return <= 0;
        rd(12'h300, 32'h0);
        irq_line[2] <= 0;
        wr(12'h280, 32'h4);
        rd(12'h200, 32'h8);
        irq_line[40] <= 1;
        rd(12'h204, 32'h100);
        $display("test core done");
        results();
    end
endmodule
bind vir_top vir_top_monitor mon (.*);
